// [design/mcs_module_clock_stop_regs.sv]
// design: module clock stop registers with glitch-free clock enables
//
// How it works
// R01: bit 5 of the serial stop register halts serial channel 2 when set, reset value 1.
// R02: bit 4 of the serial stop register halts serial channel 1 when set, reset value 1.
// R03: bit 3 of the serial stop register halts serial channel 0 when set, reset value 1.
// R04: serial register bits 7, 6 and 2..0 are writable, reset to 1, and software writes 1.
// R05: bit 6 of the timer stop register halts the multi-function timer when set, reset value 1.
// R06: bit 5 of the timer stop register halts the compare-match timer when set, reset value 1.
// R07: bit 1 of the timer stop register halts A/D unit 1 when set, reset value 1.
// R08: bit 0 of the timer stop register halts A/D unit 0 when set, reset value 1.
// R09: timer register bits 7 and 2 are writable, bits 4 and 3 read-only, all reset and read 1.
// R10: the break field at bits 1..0 runs the break controller at 00, halts it otherwise, resets to 11.
// R11: software never writes 01 or 10 to the break field.
// R12: break register bits 7..2 are read-only zero.
// R13: on small-memory variants software keeps the break field at 11.
// R14: each enable changes only at a clock edge from a flop, so gated clocks see no runt pulse.
`timescale 1ns/100ps

module mcs_module_clock_stop_regs
   import mcs_pkg::*;
(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [MCS_ADDR_W-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [3:0]            pstrb,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   output mcs_clk_en_t                clk_en
);

   ////////////////////////////////////////////////////////////////////////
   // registers: a set stop bit halts its module; everything starts halted,
   // so no module sees a clock until software releases it
   logic [7:0] serial_clock_stop;     // serial channel gates
   logic [7:0] timer_adc_clock_stop;  // timer and converter gates
   logic [7:0] break_unit_clock_stop; // break controller field

   // merge written bits with fixed bits
   function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                        input logic [7:0] wmask);
      merge = (new_v & wmask) | (old_v & ~wmask);
   endfunction

   // address hit decode
   function automatic logic hit(input logic [MCS_ADDR_W-1:0] a);
      hit = (a == MCS_ADDR_SERIAL) || (a == MCS_ADDR_TIMER) || (a == MCS_ADDR_BREAK);
   endfunction

   // stop bit to clock enable: a set stop bit halts the module,
   // a clear one lets it run
   function automatic logic gate_run(input logic [7:0] stop_v, input int pos);
      gate_run = ~stop_v[pos];
   endfunction

   // break field decode: the clock runs only when the whole field is clear;
   // the two mixed values software must not use are treated as halted
   function automatic logic break_run(input logic [7:0] stop_v);
      break_run = ((stop_v & MCS_BREAK_WMASK) == 8'(MCS_BREAK_RUN));
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // bus phases: setup, then an access phase that our pready ends
   // after one wait state
   logic access;
   logic complete;
   logic wr_lane0;
   assign access   = psel & penable;  // second and later cycles of a transfer
   assign complete = access & pready; // edge that ends the transfer
   // only byte lane 0 carries register bits; a write lands at the completing edge
   assign wr_lane0 = complete & pwrite & pstrb[0];

   // register selects
   logic sel_serial;
   logic sel_timer;
   logic sel_break;
   assign sel_serial = (paddr == MCS_ADDR_SERIAL);
   assign sel_timer  = (paddr == MCS_ADDR_TIMER);
   assign sel_break  = (paddr == MCS_ADDR_BREAK);

   // write strobes, one per register
   logic wr_serial;
   logic wr_timer;
   logic wr_break;
   assign wr_serial = wr_lane0 & sel_serial;
   assign wr_timer  = wr_lane0 & sel_timer;
   assign wr_break  = wr_lane0 & sel_break;

   // next register values; fixed bits are kept by the write masks
   logic [7:0] next_serial_clock_stop;
   logic [7:0] next_timer_adc_clock_stop;
   logic [7:0] next_break_unit_clock_stop;

   // R04 every serial bit writable
   always_comb begin
      next_serial_clock_stop = merge(serial_clock_stop, pwdata[7:0], MCS_SERIAL_WMASK);
   end

   // R09 timer bits 4 and 3 held
   always_comb begin
      next_timer_adc_clock_stop = merge(timer_adc_clock_stop, pwdata[7:0], MCS_TIMER_WMASK);
   end

   // R12 break bits 7 to 2 held at zero
   always_comb begin
      next_break_unit_clock_stop = merge(break_unit_clock_stop, pwdata[7:0], MCS_BREAK_WMASK);
   end

   ////////////////////////////////////////////////////////////////////////
   // serial stop register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // R01 R02 R03 reset halted
         serial_clock_stop <= MCS_SERIAL_RST;
      end else if (wr_serial) begin
         // R04 reserved bits writable
         // a write lands only at the edge that completes the transfer
         serial_clock_stop <= next_serial_clock_stop;
      end
   end

   // timer and converter stop register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // R05 R06 R07 R08 reset halted
         timer_adc_clock_stop <= MCS_TIMER_RST;
      end else if (wr_timer) begin
         // R09 bits 4,3 held at one
         // the mask keeps the two read-only bits at their fixed value
         timer_adc_clock_stop <= next_timer_adc_clock_stop;
      end
   end

   // break unit stop register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // R10 field resets to 11
         break_unit_clock_stop <= MCS_BREAK_RST;
      end else if (wr_break) begin
         // R12 upper bits stay zero
         // only the two field bits take the written value
         break_unit_clock_stop <= next_break_unit_clock_stop;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // clock enables: one flop per gated module, one cycle behind the stop bits
   // R14 enables come from flops only, so a gated clock never gets a runt pulse
   // an enable changes only at a clock edge, and the gating cell beyond
   // catches it in the low phase, so every pulse it passes is whole
   logic run_serial2;
   logic run_serial1;
   logic run_serial0;
   logic run_mtimer;
   logic run_ctimer;
   logic run_adc1;
   logic run_adc0;
   logic run_break;

   // R01 serial channel 2
   // reset holds the channel stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_serial2 <= 1'b0;
      end else begin
         run_serial2 <= gate_run(serial_clock_stop, MCS_SERIAL2_BIT);
      end
   end

   // R02 serial channel 1
   // reset holds the channel stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_serial1 <= 1'b0;
      end else begin
         run_serial1 <= gate_run(serial_clock_stop, MCS_SERIAL1_BIT);
      end
   end

   // R03 serial channel 0
   // reset holds the channel stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_serial0 <= 1'b0;
      end else begin
         run_serial0 <= gate_run(serial_clock_stop, MCS_SERIAL0_BIT);
      end
   end

   // R05 multi-function timer
   // reset holds the timer stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_mtimer <= 1'b0;
      end else begin
         run_mtimer <= gate_run(timer_adc_clock_stop, MCS_MTIMER_BIT);
      end
   end

   // R06 compare-match timer
   // reset holds the timer stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_ctimer <= 1'b0;
      end else begin
         run_ctimer <= gate_run(timer_adc_clock_stop, MCS_CTIMER_BIT);
      end
   end

   // R07 converter unit 1
   // reset holds the converter stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_adc1 <= 1'b0;
      end else begin
         run_adc1 <= gate_run(timer_adc_clock_stop, MCS_ADC1_BIT);
      end
   end

   // R08 converter unit 0
   // reset holds the converter stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_adc0 <= 1'b0;
      end else begin
         run_adc0 <= gate_run(timer_adc_clock_stop, MCS_ADC0_BIT);
      end
   end

   // R10 break controller runs only at 00
   // mixed field values keep it halted, the safe side
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_break <= 1'b0;
      end else begin
         run_break <= break_run(break_unit_clock_stop);
      end
   end

   // enables bundled in the carrier's field order
   // each field is a flop output with no logic after it
   assign clk_en = '{serial_channel_2:     run_serial2,
                     serial_channel_1:     run_serial1,
                     serial_channel_0:     run_serial0,
                     multi_function_timer: run_mtimer,
                     compare_match_timer:  run_ctimer,
                     adc1:                 run_adc1,
                     adc0:                 run_adc0,
                     break_controller:     run_break};

   ////////////////////////////////////////////////////////////////////////
   // bus answer: one wait state, so every access phase lasts two cycles;
   // pready rises after the first access cycle and drops at the completing
   // edge, so a transfer held longer by the master is answered again two cycles later
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= access & ~pready;
      end
   end

   // error answer for an address outside the three registers; a refused
   // write changes nothing and a refused read returns zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= access & ~pready & ~hit(paddr);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data: loaded in the first access cycle, shown while pready is high,
   // zero at all other times so the bus never sees a stale word
   logic       rd_first;
   logic [7:0] rd_byte;
   assign rd_first = access & ~pready & ~pwrite;

   // read mux over the stored words; fixed bits come back as stored
   always_comb begin
      case (paddr)
         // R04 reserved serial bits read back
         MCS_ADDR_SERIAL: rd_byte = serial_clock_stop;
         // R09 read-only timer bits read one
         MCS_ADDR_TIMER:  rd_byte = timer_adc_clock_stop;
         // R12 upper break bits read zero
         MCS_ADDR_BREAK:  rd_byte = break_unit_clock_stop;
         // unmapped reads return zero
         default:         rd_byte = 8'h00;
      endcase
   end

   // registered read word, upper lanes always zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (rd_first) begin
         prdata <= {24'h000000, rd_byte};
      end else begin
         prdata <= '0;
      end
   end

endmodule

// [inc/mcs_pkg.sv]
// package: register map, reset values and field layout of the module clock stop registers
package mcs_pkg;

   // byte addresses of the three stop registers
   localparam logic [11:0] MCS_ADDR_SERIAL = 12'h000;
   localparam logic [11:0] MCS_ADDR_TIMER  = 12'h004;
   localparam logic [11:0] MCS_ADDR_BREAK  = 12'h008;
   localparam int          MCS_ADDR_W      = 12;

   // reset values
   localparam logic [7:0] MCS_SERIAL_RST = 8'hFF;
   localparam logic [7:0] MCS_TIMER_RST  = 8'hFF;
   localparam logic [7:0] MCS_BREAK_RST  = 8'h03;

   // writable bit masks; others hold their fixed value
   localparam logic [7:0] MCS_SERIAL_WMASK = 8'hFF;
   localparam logic [7:0] MCS_TIMER_WMASK  = 8'hE7;
   localparam logic [7:0] MCS_BREAK_WMASK  = 8'h03;

   // gate bit positions
   localparam int MCS_SERIAL2_BIT = 5;
   localparam int MCS_SERIAL1_BIT = 4;
   localparam int MCS_SERIAL0_BIT = 3;
   localparam int MCS_MTIMER_BIT  = 6;
   localparam int MCS_CTIMER_BIT  = 5;
   localparam int MCS_ADC1_BIT    = 1;
   localparam int MCS_ADC0_BIT    = 0;

   // break unit field values
   localparam logic [1:0] MCS_BREAK_RUN = 2'h0;

   // clock enables bundled for the gated modules
   typedef struct packed {
      logic serial_channel_2;
      logic serial_channel_1;
      logic serial_channel_0;
      logic multi_function_timer;
      logic compare_match_timer;
      logic adc1;
      logic adc0;
      logic break_controller;
   } mcs_clk_en_t;

endpackage

// [testbench/mcs_monitor.sv]
// checker: assertions on the clock stop register ports
`timescale 1ns/100ps
module mcs_monitor
   import mcs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [MCS_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire mcs_clk_en_t clk_en
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // completed accesses by kind
   wire wr = psel & penable & pready & pwrite & pstrb[0];
   wire rd = psel & penable & pready & !pwrite;
   wire ws = wr & (paddr == MCS_ADDR_SERIAL);
   wire wt = wr & (paddr == MCS_ADDR_TIMER);
   wire wb = wr & (paddr == MCS_ADDR_BREAK);
   s2_gate_a:
   assert property (ws |=> ##1 clk_en.serial_channel_2 == !$past(pwdata[5], 2)) else $error("serial 2 gate");
   s1_gate_a:
   assert property (ws |=> ##1 clk_en.serial_channel_1 == !$past(pwdata[4], 2)) else $error("serial 1 gate");
   s0_gate_a:
   assert property (ws |=> ##1 clk_en.serial_channel_0 == !$past(pwdata[3], 2)) else $error("serial 0 gate");
   timer_gates_a:
   assert property (wt |=> ##1 clk_en[4:1] == ~$past({pwdata[6:5], pwdata[1:0]}, 2)) else $error("timer gates");
   break_gate_a:
   assert property (wb |=> ##1 clk_en[0] == ($past(pwdata[1:0], 2) == 2'h0)) else $error("break gate");
   timer_fixed_a:
   assert property (rd && paddr == MCS_ADDR_TIMER |-> prdata[4:3] == 2'h3) else $error("timer fixed bits");
   break_zero_a:
   assert property (rd && paddr == MCS_ADDR_BREAK |-> prdata[31:2] == 30'h0) else $error("break fixed bits");
   enable_lag_a:
   assert property (!$stable(clk_en) |-> $past(pready & pwrite, 2)) else $error("enable moved unasked");
   cover property (ws);
   cover property (wb);
   cover property (rd && pslverr);
endmodule
bind mcs_module_clock_stop_regs mcs_monitor u_mcs_monitor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .prdata, .pready, .pslverr, .clk_en);

// [testbench/mcs_gated_model.sv]
// partner: gating latches for the clocks of the stopped modules
`timescale 1ns/100ps
module mcs_gated_model
   import mcs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire mcs_clk_en_t clk_en,
   output logic [7:0] run
);
   // enable caught in the low phase so gated clocks get whole pulses
   always_latch begin
      if (!presetn) run <= 8'h00;
      else if (!pclk) run <= clk_en;
   end
endmodule

// [testbench/test_module_clock_stop_regs.sv]
// testbench: register accesses and gate checks
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
   $display("CHECK FAILED %0t got %h", $time, a); end end
module test_module_clock_stop_regs
   import mcs_pkg::*;
;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rerr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic [3:0] pstrb = 4'hF;
   logic [7:0] run;
   mcs_clk_en_t clk_en;
   int n_errors = 0, n_compared = 0, cycles = 0;
   // address, write byte, expected enables
   logic [27:0] tbl [11] = '{28'h000DF80, 28'h000EF40, 28'h000F720, 28'h000FF00, 28'h004BF10, 28'h004DF08,
      28'h004FD04, 28'h004FE02, 28'h004FF00, 28'h0080001, 28'h0080300};
   mcs_module_clock_stop_regs u_mcs_module_clock_stop_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .prdata, .pready, .pslverr, .clk_en);
   mcs_gated_model u_mcs_gated_model (.pclk, .presetn, .clk_en, .run);
   initial forever #2 pclk = ~pclk;
   task automatic print_verdict();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // watchdog on the whole run
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         n_errors++;
         print_verdict();
      end
   end
   task automatic do_reset();
      psel <= 1'h0;
      penable <= 1'h0;
      presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
   endtask
   // one transfer; request held until pready, psel kept for back to back use
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rdat = prdata;
      rerr = pslverr;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      `CHK(rdat, e)
      `CHK(rerr, 1'h0)
   endtask
   initial begin
      do_reset();
      `CHK(clk_en, 8'h00)
      // break field only ever 00 or 11, reserved bits written as fixed
      foreach (tbl[i]) begin
         apb(1'h1, tbl[i][27:16], {24'h0, tbl[i][15:8]});
         rd(tbl[i][27:16], {24'h0, tbl[i][15:8]});
         `CHK(clk_en, tbl[i][7:0])
         `CHK(run, tbl[i][7:0])
      end
      pstrb <= 4'h0;
      apb(1'h1, MCS_ADDR_SERIAL, 32'h0);
      pstrb <= 4'hF;
      rd(MCS_ADDR_SERIAL, 32'hFF);
      apb(1'h1, 12'h00C, 32'h0);
      `CHK(rerr, 1'h1)
      apb(1'h0, 12'h00C, 32'h0);
      `CHK(rdat, 32'h0)
      `CHK(rerr, 1'h1)
      rd(MCS_ADDR_BREAK, 32'h3);
      apb(1'h1, MCS_ADDR_SERIAL, 32'hC7);
      apb(1'h0, MCS_ADDR_SERIAL, 32'h0);
      `CHK(clk_en, 8'hE0)
      do_reset();
      `CHK(clk_en, 8'h00)
      rd(MCS_ADDR_SERIAL, 32'hFF);
      rd(MCS_ADDR_TIMER, 32'hFF);
      rd(MCS_ADDR_BREAK, 32'h3);
      print_verdict();
   end
endmodule
